//--- include/rco_defines.svh
// constants of the radio clock output control block
`ifndef RCO_DEFINES_SVH
`define RCO_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets on the serial register port
// ----------------------------------------------------------------
`define RCO_ADDR_CTL 6'h0A
`define RCO_ADDR_ATT 6'h24

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define RCO_CTL_RESET 16'h8026
`define RCO_RATE_DEFAULT 3'h6
`define RCO_ATT_STATUS_BIT 0
`define RCO_ATT_MASK_BIT 8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCO_MCLK_KHZ 125000
`define RCO_STARTUP_MS 10
// half-period tick of the 16 MHz reference: 2^32 * 32 / 125
`define RCO_NCO_BASE 32'h4189_374C
// one trim step, a couple of hertz on the reference
`define RCO_TRIM_STEP 32'h0000_0080

// reference periods per output period, per rate code
`define RCO_DIV_0 10'h001
`define RCO_DIV_1 10'h002
`define RCO_DIV_2 10'h004
`define RCO_DIV_3 10'h008
`define RCO_DIV_4 10'h010
`define RCO_DIV_5 10'h100
`define RCO_DIV_6 10'h1E8
`define RCO_DIV_7 10'h3D0

`endif

//--- include/rco_pkg.sv
// types of the radio clock output control block
`default_nettype none
`include "rco_defines.svh"

package rco_pkg;

    typedef struct packed {
        logic [7:0] trim;
        logic [1:0] rsvd;
        logic enable;
        logic doze_keep;
        logic slew;
        logic [2:0] rate;
    } rco_ctl_t;

    typedef enum logic [1:0] {
        ST_WAIT = 2'b01,
        ST_READY = 2'b10
    } rco_state_t;

    function automatic logic [9:0] rco_divisor(input logic [2:0] rate);
        logic [9:0] d;
        d = `RCO_DIV_0;
        case (rate)
            3'h1: d = `RCO_DIV_1;
            3'h2: d = `RCO_DIV_2;
            3'h3: d = `RCO_DIV_3;
            3'h4: d = `RCO_DIV_4;
            3'h5: d = `RCO_DIV_5;
            3'h6: d = `RCO_DIV_6;
            3'h7: d = `RCO_DIV_7;
            default: d = `RCO_DIV_0;
        endcase
        return d;
    endfunction

endpackage

`default_nettype wire

//--- hdl/rco_clkdiv.sv
// glitch-free divider of the reference half-period ticks
`timescale 1ns/1ps
`default_nettype none
`include "rco_defines.svh"

module rco_clkdiv (
    input wire logic clk,
    input wire logic srst,
    input wire logic half_tick,
    input wire logic [2:0] rate_sel,
    input wire logic run,
    output logic clk_out
);

    logic [9:0] cnt_r;
    logic [9:0] cnt_nxt;
    logic out_r;
    logic out_nxt;
    logic [2:0] rate_r;
    logic [2:0] rate_nxt;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    always_comb
    begin
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        rate_nxt = rate_r;
        if (half_tick)
        begin
            if (cnt_r == rco_pkg::rco_divisor(rate_r) - 10'h001)
            begin
                cnt_nxt = 10'h000;
                if (out_r)
                begin
                    // new rate only at a phase end, here the falling edge: no runt pulse
                    out_nxt = 1'b0;
                    rate_nxt = rate_sel;
                end
                else
                begin
                    // a stopped clock parks low and restarts whole
                    out_nxt = run;
                    rate_nxt = rate_sel;
                end
            end
            else
            begin
                cnt_nxt = cnt_r + 10'h001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_r <= 10'h000;
            out_r <= 1'b0;
            rate_r <= `RCO_RATE_DEFAULT;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
            rate_r <= rate_nxt;
        end
    end

    assign clk_out = out_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_rate_boundary: assert property (@(posedge clk) disable iff (srst)
        $changed(rate_r) |-> !$past(out_r) || !out_r)
        else $error("divider rate switched inside a high phase");

    a_rise_needs_run: assert property (@(posedge clk) disable iff (srst)
        $rose(out_r) |-> $past(run))
        else $error("divided clock rose while stopped");

endmodule // rco_clkdiv

`default_nettype wire

//--- hdl/rco_top.sv
// clock output and crystal trim control of the radio transceiver
//
// Contract
// - eight-bit trim code in control bits 15-8
// - larger trim code lowers reference frequency
// - software selects output rate, 16 kHz-16 MHz
// - start-up interrupt, default output about 32 kHz
// - after forced off, output waits start-up time
// - doze keeps output running when configured
// - programmable output slew, no pull-up
// - in reset, nothing runs, output undriven
// - end of start-up wait sets attention status and mask
`timescale 1ns/1ps
`default_nettype none
`include "rco_defines.svh"

module rco_top #(
    parameter int STARTUP_CYCLES = `RCO_STARTUP_MS * `RCO_MCLK_KHZ
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic DOZE,
    input wire logic [5:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic IRQ_N_O,
    output logic IRQ_N_OE,
    output logic DIVIDED_CLOCK_OUT,
    output logic DIVIDED_CLOCK_OUT_OE,
    output logic DIVIDED_CLOCK_SLEW,
    output logic [7:0] OSC_TRIM
);

    rco_pkg::rco_state_t state_r;
    rco_pkg::rco_state_t state_nxt;
    logic [20:0] cnt_r;
    logic [20:0] cnt_nxt;
    logic ready_pulse;
    logic ready;

    rco_pkg::rco_ctl_t ctl_r;
    rco_pkg::rco_ctl_t ctl_nxt;
    logic att_r;
    logic att_nxt;
    logic mask_r;
    logic mask_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic tick_r;
    logic tick_nxt;
    logic [31:0] nco_inc;

    logic run;
    logic div_out;
    logic pin_r;
    logic pin_nxt;
    logic pin_oe_r;
    logic pin_oe_nxt;
    logic irq_oe_r;
    logic irq_oe_nxt;
    logic slew_r;
    logic slew_nxt;

    // ----------------------------------------------------------------
    // start-up after reset release
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ready_pulse = 1'b0;
        case (state_r)
            rco_pkg::ST_WAIT:
            begin
                if (cnt_r == 21'(STARTUP_CYCLES - 1))
                begin
                    state_nxt = rco_pkg::ST_READY;
                    ready_pulse = 1'b1;
                end
                else
                begin
                    cnt_nxt = cnt_r + 21'h00_0001;
                end
            end
            rco_pkg::ST_READY:
            begin
                state_nxt = rco_pkg::ST_READY;
            end
            default:
            begin
                state_nxt = rco_pkg::ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            state_r <= rco_pkg::ST_WAIT;
            cnt_r <= 21'h00_0000;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign ready = (state_r == rco_pkg::ST_READY);

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // accesses before start-up are dropped: the core is not alive yet
    always_comb
    begin
        ctl_nxt = ctl_r;
        att_nxt = att_r;
        mask_nxt = mask_r;
        rdata_nxt = rdata_r;
        if (ready && REG_WR)
        begin
            if (REG_ADDR == `RCO_ADDR_CTL)
            begin
                ctl_nxt = rco_pkg::rco_ctl_t'(REG_WDATA);
                ctl_nxt.rsvd = 2'h0;
            end
            else if (REG_ADDR == `RCO_ADDR_ATT)
            begin
                mask_nxt = REG_WDATA[`RCO_ATT_MASK_BIT];
            end
        end
        if (ready && REG_RD)
        begin
            rdata_nxt = 16'h0000;
            if (REG_ADDR == `RCO_ADDR_CTL)
            begin
                rdata_nxt = ctl_r;
            end
            else if (REG_ADDR == `RCO_ADDR_ATT)
            begin
                rdata_nxt[`RCO_ATT_STATUS_BIT] = att_r;
                rdata_nxt[`RCO_ATT_MASK_BIT] = mask_r;
                att_nxt = 1'b0;
            end
        end
        // set wins over a clearing read in the same cycle
        if (ready_pulse)
        begin
            att_nxt = 1'b1;
            mask_nxt = 1'b1;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ctl_r <= rco_pkg::rco_ctl_t'(`RCO_CTL_RESET);
            att_r <= 1'b0;
            mask_r <= 1'b0;
            rdata_r <= 16'h0000;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            att_r <= att_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // trimmed reference: half-period ticks of the 16 MHz clock
    // ----------------------------------------------------------------
    // the tick jitters by one MCLK cycle; average rate is exact
    assign nco_inc = `RCO_NCO_BASE - 32'(ctl_r.trim) * `RCO_TRIM_STEP;

    always_comb
    begin
        {tick_nxt, acc_nxt} = {1'b0, acc_r} + {1'b0, nco_inc};
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            acc_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ----------------------------------------------------------------
    // divided clock and pins
    // ----------------------------------------------------------------
    assign run = ready && ctl_r.enable && (!DOZE || ctl_r.doze_keep);

    rco_clkdiv u_div (
        .clk(MCLK),
        .srst(SRST),
        .half_tick(tick_r),
        .rate_sel(ctl_r.rate),
        .run(run),
        .clk_out(div_out)
    );

    always_comb
    begin
        pin_oe_nxt = ready;
        pin_nxt = div_out && ready;
        irq_oe_nxt = att_r && mask_r;
        slew_nxt = ctl_r.slew;
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            pin_r <= 1'b0;
            pin_oe_r <= 1'b0;
            irq_oe_r <= 1'b0;
            slew_r <= 1'b0;
        end
        else
        begin
            pin_r <= pin_nxt;
            pin_oe_r <= pin_oe_nxt;
            irq_oe_r <= irq_oe_nxt;
            slew_r <= slew_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign IRQ_N_O = 1'b0;
    assign IRQ_N_OE = irq_oe_r;
    assign DIVIDED_CLOCK_OUT = pin_r;
    assign DIVIDED_CLOCK_OUT_OE = pin_oe_r;
    assign DIVIDED_CLOCK_SLEW = slew_r;
    assign OSC_TRIM = ctl_r.trim;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    sequence s_count_end;
        state_r == rco_pkg::ST_WAIT && cnt_r == 21'(STARTUP_CYCLES - 1);
    endsequence

    sequence s_irq_up;
        att_r && mask_r ##1 IRQ_N_OE;
    endsequence

    a_startup_irq: assert property (s_count_end |=> s_irq_up)
        else $error("start-up interrupt not raised on time");

    a_quiet_wait: assert property (
        state_r == rco_pkg::ST_WAIT |-> !DIVIDED_CLOCK_OUT_OE && !pin_r)
        else $error("clock pin driven before start-up ended");

    a_default_rate: assert property (
        $rose(ready) |-> ctl_r.rate == `RCO_RATE_DEFAULT)
        else $error("output rate not at default after start-up");

    a_trim_write: assert property (
        ready && REG_WR && REG_ADDR == `RCO_ADDR_CTL
        |=> OSC_TRIM == $past(REG_WDATA[15:8]))
        else $error("trim code not taken from bits 15-8");

    a_trim_slope: assert property (
        ctl_r.trim > $past(ctl_r.trim) |-> nco_inc < $past(nco_inc))
        else $error("larger trim code did not lower frequency");

    a_rate_write: assert property (
        ready && REG_WR && REG_ADDR == `RCO_ADDR_CTL
        |=> ctl_r.rate == $past(REG_WDATA[2:0]))
        else $error("rate select not stored");

    a_doze_stop: assert property (
        (ready && DOZE && !ctl_r.doze_keep)[*2] |-> !$rose(div_out))
        else $error("clock started in doze without keep-alive");

    a_slew_follow: assert property (
        ##1 DIVIDED_CLOCK_SLEW == $past(ctl_r.slew))
        else $error("slew pin does not follow control bit");

    a_read_clear: assert property (
        ready && REG_RD && REG_ADDR == `RCO_ADDR_ATT && !ready_pulse
        |=> !att_r ##1 !IRQ_N_OE)
        else $error("attention status not cleared by read");

endmodule // rco_top

`default_nettype wire

//--- tb/rco_host_model.sv
// host-side model: clock input pin and interrupt line of the controller
`timescale 1ns/1ps
`default_nettype none

module rco_host_model (
    input wire logic clk,
    input wire logic pin_level,
    input wire logic pin_oe,
    input wire logic irq_level,
    input wire logic irq_oe,
    output logic clk_wire,
    output logic irq_wire,
    output logic [15:0] high_len,
    output logic [15:0] high_cnt
);
    logic last_r = 1'b0;
    logic [15:0] run_r = 16'h0000;
    logic [15:0] len_r = 16'h0000;
    logic [15:0] cnt_r = 16'h0000;

    // no pull-up on the clock pin: an undriven wire keeps changing
    assign clk_wire = pin_oe ? pin_level : ~last_r;
    // pull-up on the interrupt line, released while not pulled
    assign irq_wire = irq_oe ? irq_level : 1'b1;
    assign high_len = len_r;
    assign high_cnt = cnt_r;

    // length of each completed high phase, in host clock cycles
    always @(posedge clk)
    begin
        last_r <= clk_wire;
        if (!pin_oe)
            run_r <= 16'h0000;
        else if (clk_wire)
            run_r <= run_r + 16'h0001;
        else if (last_r)
        begin
            len_r <= run_r;
            cnt_r <= cnt_r + 16'h0001;
            run_r <= 16'h0000;
        end
    end
endmodule // rco_host_model
`default_nettype wire

//--- tb/rco_top_tb.sv
// self-checking bench of the radio clock output control block
`timescale 1ns/1ps
`default_nettype none
`include "rco_defines.svh"

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module rco_top_tb;
    localparam int SU = 50;
    logic MCLK = 1'b0;
    logic SRST = 1'b1;
    logic DOZE = 1'b0;
    logic [5:0] REG_ADDR = 6'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [15:0] REG_WDATA = 16'h0000;
    logic [15:0] REG_RDATA, high_len, high_cnt, rd, c;
    logic IRQ_N_O, IRQ_N_OE, DIVIDED_CLOCK_OUT, DIVIDED_CLOCK_OUT_OE;
    logic DIVIDED_CLOCK_SLEW, clk_wire, irq_wire;
    logic [7:0] OSC_TRIM;
    int fail_count = 0;
    int checked = 0;
    int divs [8] = '{`RCO_DIV_0, `RCO_DIV_1, `RCO_DIV_2, `RCO_DIV_3,
        `RCO_DIV_4, `RCO_DIV_5, `RCO_DIV_6, `RCO_DIV_7};

    always #4 MCLK = ~MCLK;

    rco_top #(.STARTUP_CYCLES(SU)) u_rco_top (.MCLK(MCLK), .SRST(SRST),
        .DOZE(DOZE), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .IRQ_N_O(IRQ_N_O),
        .IRQ_N_OE(IRQ_N_OE), .DIVIDED_CLOCK_OUT(DIVIDED_CLOCK_OUT),
        .DIVIDED_CLOCK_OUT_OE(DIVIDED_CLOCK_OUT_OE),
        .DIVIDED_CLOCK_SLEW(DIVIDED_CLOCK_SLEW), .OSC_TRIM(OSC_TRIM));

    rco_host_model u_rco_host_model (.clk(MCLK),
        .pin_level(DIVIDED_CLOCK_OUT), .pin_oe(DIVIDED_CLOCK_OUT_OE),
        .irq_level(IRQ_N_O), .irq_oe(IRQ_N_OE), .clk_wire(clk_wire),
        .irq_wire(irq_wire), .high_len(high_len), .high_cnt(high_cnt));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    task automatic reg_write(logic [5:0] a, logic [15:0] d);
        @(posedge MCLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge MCLK);
        REG_WR <= 1'b0;
        #1;
    endtask

    task automatic reg_read(logic [5:0] a, output logic [15:0] d);
        @(posedge MCLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask

    // waits for the next completed high phase of the output clock
    task automatic next_phase(output int len);
        logic [15:0] c0;
        c0 = high_cnt;
        for (int i = 0; i < 20000; i++)
        begin
            tick(1);
            if (high_cnt !== c0)
            begin
                len = high_len;
                return;
            end
        end
        fail_count++;
        final_report();
    endtask

    function automatic logic [15:0] ctl(logic [7:0] t, logic en, logic dk,
        logic sl, logic [2:0] r);
        return {t, 2'b00, en, dk, sl, r};
    endfunction

    // half period in host cycles, reference ticks jitter by one cycle
    function automatic logic near(int a, int r);
        return (a >= divs[r] * 125 / 32 - 2) && (a <= divs[r] * 125 / 32 + 2);
    endfunction

    // ------------------------------------------------------------
    // reset, start-up wait and default state
    // ------------------------------------------------------------
    task automatic startup(string name);
        int t_irq;
        int t_oe;
        int len;
        t_irq = 0;
        t_oe = 0;
        @(posedge MCLK);
        SRST <= 1'b1;
        tick(10);
        `CHK(DIVIDED_CLOCK_OUT_OE, 1'b0)
        `CHK(IRQ_N_OE, 1'b0)
        `CHK(OSC_TRIM, 8'h80)
        @(posedge MCLK);
        SRST <= 1'b0;
        REG_ADDR <= `RCO_ADDR_CTL;
        REG_WDATA <= 16'h0000;
        // host writes the control register at cycle 4, before the interrupt line falls
        for (int i = 1; i < 200 && t_oe == 0; i++)
        begin
            @(posedge MCLK);
            REG_WR <= (i == 4);
            #1;
            if (irq_wire === 1'b0 && t_irq == 0)
                t_irq = i;
            if (DIVIDED_CLOCK_OUT_OE === 1'b1 && t_oe == 0)
                t_oe = i;
        end
        `CHK(t_irq >= SU && t_irq <= SU + 2, 1'b1)
        `CHK(t_oe >= SU && t_oe <= SU + 2, 1'b1)
        reg_read(`RCO_ADDR_ATT, rd);
        `CHK(rd, 16'h0101)
        tick(1);
        `CHK(irq_wire, 1'b1)
        reg_read(`RCO_ADDR_CTL, rd);
        `CHK(rd, `RCO_CTL_RESET)
        next_phase(len);
        next_phase(len);
        `CHK(near(len, `RCO_RATE_DEFAULT), 1'b1)
        $display("test %s done", name);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int len;
        int prev;
        int lo;
        startup("startup");
        prev = divs[6] * 125 / 32;
        for (int r = 0; r < 8; r++)
        begin
            reg_write(`RCO_ADDR_CTL, ctl(8'h80, 1'b1, 1'b0, 1'b0, r[2:0]));
            lo = (prev < divs[r] * 125 / 32 ? prev : divs[r] * 125 / 32) - 2;
            next_phase(len);
            `CHK(len >= lo, 1'b1)
            next_phase(len);
            `CHK(len >= lo, 1'b1)
            next_phase(len);
            `CHK(near(len, r), 1'b1)
            prev = divs[r] * 125 / 32;
        end
        $display("test rates done");
        for (int k = 0; k < 2; k++)
        begin
            reg_write(`RCO_ADDR_CTL, ctl(k ? 8'h00 : 8'hFF, 1'b1, 1'b0,
                !k, 3'h0));
            tick(2);
            `CHK(OSC_TRIM, k ? 8'h00 : 8'hFF)
            `CHK(DIVIDED_CLOCK_SLEW, !k)
        end
        reg_write(6'h3F, 16'hFFFF);
        reg_read(6'h3F, rd);
        `CHK(rd, 16'h0000)
        reg_read(`RCO_ADDR_CTL, rd);
        `CHK(rd, 16'h0020)
        // mask written low: status stays clear, line stays released
        reg_write(`RCO_ADDR_ATT, 16'h0000);
        reg_read(`RCO_ADDR_ATT, rd);
        `CHK(rd, 16'h0000)
        `CHK(irq_wire, 1'b1)
        $display("test trim done");
        @(posedge MCLK);
        DOZE <= 1'b1;
        tick(20);
        c = high_cnt;
        tick(100);
        `CHK(high_cnt, c)
        `CHK(clk_wire, 1'b0)
        reg_write(`RCO_ADDR_CTL, ctl(8'h80, 1'b1, 1'b1, 1'b0, 3'h0));
        next_phase(len);
        next_phase(len);
        `CHK(near(len, 0), 1'b1)
        @(posedge MCLK);
        DOZE <= 1'b0;
        reg_write(`RCO_ADDR_CTL, ctl(8'h80, 1'b0, 1'b0, 1'b0, 3'h0));
        tick(20);
        c = high_cnt;
        tick(100);
        `CHK(high_cnt, c)
        `CHK(DIVIDED_CLOCK_OUT_OE, 1'b1)
        $display("test doze done");
        startup("restart");
        final_report();
    end
endmodule // rco_top_tb
`default_nettype wire
